/* File: hw/sprl_regbank.sv */
// Priority regeneration, learn-discard counters and interrupt mask behind an AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps

// Functional notes
// - Eight writable 3-bit regeneration fields, priority 7 on top, priority 0 lowest.
// - Each received priority is replaced by its field value for queue selection.
// - After reset every field holds its own priority index.
// - A port's count increments when an address is not learned or overwritten.
// - Three separate 32-bit counters, one per port, each at its own register.
// - Reading a counter returns the full count and then clears it.
// - Counters stop at all ones and never wrap.
// - Global mask bit 0 blocks all switch interrupts; it resets set.
// - Clearing the global mask lets pending interrupts through again.
// - The mask leaves status bits untouched; events keep being recorded.
module sprl_regbank
   import sprl_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [DATA_W-1:0] S_AXI_WDATA_I,
   input wire logic [STRB_W-1:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [DATA_W-1:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic RX_PRIO_VALID_I,
   input wire logic [PRIO_W-1:0] RX_PRIO_I,
   output logic REGEN_VALID_O,
   output logic [PRIO_W-1:0] REGEN_PRIO_O,
   input wire logic [NPORT-1:0] LEARN_DISCARD_I,
   input wire logic SWITCH_INTERRUPT_PENDING_I,
   output logic SWITCH_IRQ_O
);

   logic aw_rdy_r;
   logic aw_held_r;
   logic [13:0] aw_idx_r;
   logic w_rdy_r;
   logic w_held_r;
   logic [DATA_W-1:0] w_data_r;
   logic [STRB_W-1:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic ar_rdy_r;
   logic rvalid_r;
   sprl_rd_t rd_r;
   sprl_rd_t rd_nxt;
   sprl_regen_t regen_r;
   logic mask_r;
   logic [EV_W-1:0] evstat_r;
   logic [EV_W-1:0] evmask_r;
   logic [31:0] cnt_r [NPORT];
   logic regen_valid_r;
   logic [PRIO_W-1:0] regen_prio_r;
   logic irq_r;
   logic wr_fire;
   logic rd_fire;
   logic [13:0] ar_idx;
   logic [DATA_W-1:0] wmask;
   logic [DATA_W-1:0] regen_wr;
   logic [PRIO_W-1:0] sel_prio;

   assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
   assign rd_fire = S_AXI_ARVALID_I && ar_rdy_r;
   assign ar_idx = S_AXI_ARADDR_I[15:2];
   assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   assign regen_wr = ({8'h00, regen_r} & ~wmask) | (w_data_r & wmask);
   assign sel_prio = regen_r[RX_PRIO_I*PRIO_W +: PRIO_W];

   // Write address channel; the slot is held until the response is sent.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         aw_rdy_r <= 1'b0;
         aw_held_r <= 1'b0;
         aw_idx_r <= 14'h0000;
      end else if (S_AXI_AWVALID_I && aw_rdy_r) begin
         aw_rdy_r <= 1'b0;
         aw_held_r <= 1'b1;
         aw_idx_r <= S_AXI_AWADDR_I[15:2];
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end else if (!aw_held_r && !bvalid_r) begin
         aw_rdy_r <= 1'b1;
      end
   end

   // Write data channel, accepted independently of the address.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         w_rdy_r <= 1'b0;
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (S_AXI_WVALID_I && w_rdy_r) begin
         w_rdy_r <= 1'b0;
         w_held_r <= 1'b1;
         w_data_r <= S_AXI_WDATA_I;
         w_strb_r <= S_AXI_WSTRB_I;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end else if (!w_held_r && !bvalid_r) begin
         w_rdy_r <= 1'b1;
      end
   end

   // Write response; unmapped addresses answer with a slave error.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         if (aw_idx_r == IDX_REGEN2 || aw_idx_r == IDX_MASK || aw_idx_r == IDX_EVMASK) begin
            bresp_r <= RESP_OKAY;
         end else if (aw_idx_r == IDX_CNT0 || aw_idx_r == IDX_CNT1 || aw_idx_r == IDX_CNT2) begin
            bresp_r <= RESP_OKAY;
         end else if (aw_idx_r == IDX_EVSTAT) begin
            bresp_r <= RESP_OKAY;
         end else begin
            bresp_r <= RESP_SLVERR;
         end
      end else if (S_AXI_BREADY_I) begin
         bvalid_r <= 1'b0;
      end
   end

   // Writable registers; only documented field bits are stored.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         regen_r <= REGEN_RST;
         mask_r <= MASK_RST;
         evmask_r <= EV_RST;
      end else if (wr_fire) begin
         if (aw_idx_r == IDX_REGEN2) begin
            regen_r <= regen_wr[REGEN_W-1:0];
         end else if (aw_idx_r == IDX_MASK) begin
            if (w_strb_r[0]) begin
               mask_r <= w_data_r[MASK_BIT];
            end
         end else if (aw_idx_r == IDX_EVMASK) begin
            if (w_strb_r[0]) begin
               evmask_r <= w_data_r[EV_W-1:0];
            end
         end
      end
   end

   // Read decode; the answer is captured at the address handshake.
   always_comb begin
      rd_nxt.resp = RESP_OKAY;
      rd_nxt.data = 32'h0000_0000;
      if (ar_idx == IDX_REGEN2) begin
         rd_nxt.data = {8'h00, regen_r};
      end else if (ar_idx == IDX_CNT0) begin
         rd_nxt.data = cnt_r[0];
      end else if (ar_idx == IDX_CNT1) begin
         rd_nxt.data = cnt_r[1];
      end else if (ar_idx == IDX_CNT2) begin
         rd_nxt.data = cnt_r[2];
      end else if (ar_idx == IDX_MASK) begin
         rd_nxt.data = {31'h0000_0000, mask_r};
      end else if (ar_idx == IDX_EVSTAT) begin
         rd_nxt.data = {29'h0000_0000, evstat_r};
      end else if (ar_idx == IDX_EVMASK) begin
         rd_nxt.data = {29'h0000_0000, evmask_r};
      end else begin
         rd_nxt.resp = RESP_SLVERR;
      end
   end

   // Read channel.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         ar_rdy_r <= 1'b0;
         rvalid_r <= 1'b0;
         rd_r <= '0;
      end else if (rd_fire) begin
         ar_rdy_r <= 1'b0;
         rvalid_r <= 1'b1;
         rd_r <= rd_nxt;
      end else if (rvalid_r) begin
         if (S_AXI_RREADY_I) begin
            rvalid_r <= 1'b0;
         end
      end else begin
         ar_rdy_r <= 1'b1;
      end
   end

   // Learn-discard counters; an event in the clearing cycle counts as one.
   for (genvar i = 0; i < NPORT; i++) begin : g_cnt
      logic clr;
      assign clr = rd_fire && ar_idx == IDX_CNT0 + 14'(i);
      always_ff @(posedge SYS_CLK_I) begin
         if (!RST_N_I) begin
            cnt_r[i] <= CNT_RST;
         end else if (clr) begin
            cnt_r[i] <= {31'h0000_0000, LEARN_DISCARD_I[i]};
         end else if (LEARN_DISCARD_I[i] && cnt_r[i] != CNT_MAX) begin
            cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
         end
      end

      property p_cnt_inc;
         @(posedge SYS_CLK_I) disable iff (!RST_N_I)
         LEARN_DISCARD_I[i] && !clr && cnt_r[i] != CNT_MAX |=> cnt_r[i] == $past(cnt_r[i]) + 1;
      endproperty
      a_cnt_inc: assert property (p_cnt_inc) else $error("Counter missed an event.");

      property p_cnt_sat;
         @(posedge SYS_CLK_I) disable iff (!RST_N_I)
         cnt_r[i] == CNT_MAX && !clr |=> cnt_r[i] == CNT_MAX;
      endproperty
      a_cnt_sat: assert property (p_cnt_sat) else $error("Counter left saturation.");

      sequence s_cnt_read;
         clr ##1 S_AXI_RVALID_O;
      endsequence
      property p_cnt_read;
         @(posedge SYS_CLK_I) disable iff (!RST_N_I)
         s_cnt_read |-> S_AXI_RDATA_O == $past(cnt_r[i])
            && cnt_r[i] == {31'h0000_0000, $past(LEARN_DISCARD_I[i])};
      endproperty
      a_cnt_read: assert property (p_cnt_read) else $error("Counter read or clear wrong.");
   end

   // Event status is recorded whatever the masks say; a read clears, a new event wins.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         evstat_r <= EV_RST;
      end else if (rd_fire && ar_idx == IDX_EVSTAT) begin
         evstat_r <= LEARN_DISCARD_I;
      end else begin
         evstat_r <= evstat_r | LEARN_DISCARD_I;
      end
   end

   // Interrupt request, registered so the pin comes straight from a flip-flop.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= !mask_r && (SWITCH_INTERRUPT_PENDING_I || |(evstat_r & ~evmask_r));
      end
   end

   // Priority regeneration; one cycle of latency per received frame.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         regen_valid_r <= 1'b0;
         regen_prio_r <= 3'h0;
      end else begin
         regen_valid_r <= RX_PRIO_VALID_I;
         if (RX_PRIO_VALID_I) begin
            regen_prio_r <= sel_prio;
         end
      end
   end

   assign S_AXI_AWREADY_O = aw_rdy_r;
   assign S_AXI_WREADY_O = w_rdy_r;
   assign S_AXI_BVALID_O = bvalid_r;
   assign S_AXI_BRESP_O = bresp_r;
   assign S_AXI_ARREADY_O = ar_rdy_r;
   assign S_AXI_RVALID_O = rvalid_r;
   assign S_AXI_RDATA_O = rd_r.data;
   assign S_AXI_RRESP_O = rd_r.resp;
   assign REGEN_VALID_O = regen_valid_r;
   assign REGEN_PRIO_O = regen_prio_r;
   assign SWITCH_IRQ_O = irq_r;

   property p_regen_map;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RX_PRIO_VALID_I |=> REGEN_VALID_O && REGEN_PRIO_O == $past(sel_prio);
   endproperty
   a_regen_map: assert property (p_regen_map) else $error("Regenerated priority wrong.");

   property p_regen_field;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RX_PRIO_VALID_I && RX_PRIO_I == 3'h7 |-> sel_prio == regen_r.prio7_mapped_value;
   endproperty
   a_regen_field: assert property (p_regen_field) else $error("Priority 7 field misplaced.");

   property p_regen_rst;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $rose(RST_N_I) |-> regen_r == REGEN_RST && regen_r.prio0_mapped_value == 3'h0;
   endproperty
   a_regen_rst: assert property (p_regen_rst) else $error("Table not identity after reset.");

   property p_mask_rst;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $rose(RST_N_I) |-> mask_r ##1 !SWITCH_IRQ_O;
   endproperty
   a_mask_rst: assert property (p_mask_rst) else $error("Mask not set after reset.");

   property p_irq_blocked;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      mask_r |=> !SWITCH_IRQ_O;
   endproperty
   a_irq_blocked: assert property (p_irq_blocked) else $error("Interrupt leaked past mask.");

   sequence s_unmasked_pend;
      !mask_r && SWITCH_INTERRUPT_PENDING_I;
   endsequence
   property p_irq_pass;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      s_unmasked_pend |=> SWITCH_IRQ_O;
   endproperty
   a_irq_pass: assert property (p_irq_pass) else $error("Unmasked pending not signalled.");

   property p_irq_cause;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      SWITCH_IRQ_O |-> $past(!mask_r)
         && $past(SWITCH_INTERRUPT_PENDING_I || |(evstat_r & ~evmask_r));
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("Interrupt without a cause.");

   property p_status_kept;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      mask_r && LEARN_DISCARD_I[0] |=> evstat_r[0];
   endproperty
   a_status_kept: assert property (p_status_kept) else $error("Event lost under mask.");

   sequence s_regen_read;
      rd_fire && ar_idx == IDX_REGEN2 ##1 S_AXI_RVALID_O;
   endsequence
   property p_rsvd_zero;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      s_regen_read |-> S_AXI_RDATA_O[31:24] == 8'h00;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits not zero.");

   property p_cnt_addr;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      rd_fire && ar_idx == IDX_CNT2 |=> S_AXI_RDATA_O == $past(cnt_r[2]);
   endproperty
   a_cnt_addr: assert property (p_cnt_addr) else $error("Port 2 counter misdecoded.");

endmodule

/* File: hw/sprl_pkg.sv */
// Constants and types shared by the priority regeneration and learn-discard register bank.
package sprl_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int NPORT = 3;
   localparam int PRIO_W = 3;
   localparam int STRB_W = 4;

   // Register indices; the byte address is four times the index.
   localparam logic [13:0] IDX_REGEN2 = 14'h1857;
   localparam logic [13:0] IDX_CNT0 = 14'h1858;
   localparam logic [13:0] IDX_CNT1 = 14'h1859;
   localparam logic [13:0] IDX_CNT2 = 14'h185A;
   localparam logic [13:0] IDX_MASK = 14'h1880;
   localparam logic [13:0] IDX_EVSTAT = 14'h1890;
   localparam logic [13:0] IDX_EVMASK = 14'h1891;

   // Field positions and widths.
   localparam int REGEN_W = 24;
   localparam int MASK_BIT = 0;
   localparam int EV_W = 3;

   // Reset values and the counter saturation value.
   localparam logic [23:0] REGEN_RST = 24'hFAC688;
   localparam logic MASK_RST = 1'b1;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;
   localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
   localparam logic [2:0] EV_RST = 3'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Regeneration table, field for priority 7 in the top bits.
   typedef struct packed {
      logic [2:0] prio7_mapped_value;
      logic [2:0] prio6_mapped_value;
      logic [2:0] prio5_mapped_value;
      logic [2:0] prio4_mapped_value;
      logic [2:0] prio3_mapped_value;
      logic [2:0] prio2_mapped_value;
      logic [2:0] prio1_mapped_value;
      logic [2:0] prio0_mapped_value;
   } sprl_regen_t;

   // One read answer as it is loaded into the read channel.
   typedef struct packed {
      logic [1:0] resp;
      logic [31:0] data;
   } sprl_rd_t;

endpackage

/* File: verification/switch_prio_regen_learn_count_tb_top.sv */
// Self-checking testbench for the priority regeneration and learn-discard register bank.
`timescale 1ns/100ps
module switch_prio_regen_learn_count_tb_top;
   import sprl_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] awaddr = 16'h0000;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wvalid = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic bready = 1'b0;
   logic [15:0] araddr = 16'h0000;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic rx_valid = 1'b0;
   logic [2:0] rx_prio = 3'h0;
   logic [2:0] learn = 3'h0;
   logic pending = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, regen_valid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [2:0] regen_prio;
   int n_errors = 0;
   int cmp_count = 0;

   always #12.5 clk = ~clk;

   sprl_regbank uut (
      .SYS_CLK_I(clk), .RST_N_I(rst_n),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .RX_PRIO_VALID_I(rx_valid),
      .RX_PRIO_I(rx_prio), .REGEN_VALID_O(regen_valid), .REGEN_PRIO_O(regen_prio),
      .LEARN_DISCARD_I(learn), .SWITCH_INTERRUPT_PENDING_I(pending), .SWITCH_IRQ_O(irq)
   );

   task automatic finish_test;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk_val(input string name, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", name, e, g);
         n_errors++;
      end
   endtask

   // Tasks start just after a rising edge and end one edge after releasing the bus.
   task automatic wr_chk(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
      bit aw_ok;
      bit w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= {idx, 2'h0};
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // No cycle count is assumed; only the watchdog ends a wait that never finishes.
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge clk);
      end while (bvalid !== 1'b1);
      chk_val("bresp", {30'h0, er}, {30'h0, bresp});
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [13:0] idx, input logic [31:0] ed, input logic [1:0] er);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge clk);
      end while (rvalid !== 1'b1);
      chk_val("rdata", ed, rdata);
      chk_val("rresp", {30'h0, er}, {30'h0, rresp});
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // The answer is registered, so it is looked at two edges after the request is driven.
   task automatic prio_chk(input logic [2:0] p, input logic [2:0] e);
      rx_valid <= 1'b1;
      rx_prio <= p;
      @(posedge clk);
      rx_valid <= 1'b0;
      @(posedge clk);
      chk_val("regen_valid", 32'h1, {31'h0, regen_valid});
      chk_val("regen_prio", {29'h0, e}, {29'h0, regen_prio});
   endtask

   task automatic learn_pulse(input int port, input int cnt);
      learn <= 3'(1 << port);
      repeat (cnt) @(posedge clk);
      learn <= 3'h0;
      @(posedge clk);
   endtask

   // Three cycles covers the two-cycle event-to-interrupt path with margin.
   task automatic irq_chk(input logic e);
      repeat (3) @(posedge clk);
      chk_val("irq", {31'h0, e}, {31'h0, irq});
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test();
   end

   initial begin
      logic [31:0] tbl;
      int i;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(IDX_REGEN2, 32'h00FA_C688, RESP_OKAY);
      rd_chk(IDX_MASK, 32'h0000_0001, RESP_OKAY);
      for (i = 0; i < 8; i++) prio_chk(3'(i), 3'(i));
      tbl = 32'h0000_0000;
      for (i = 0; i < 8; i++) tbl[3*i+:3] = 3'(7 - i);
      wr_chk(IDX_REGEN2, tbl | 32'hFF00_0000, RESP_OKAY);
      rd_chk(IDX_REGEN2, tbl, RESP_OKAY);
      for (i = 0; i < 8; i++) prio_chk(3'(i), 3'(7 - i));
      for (i = 0; i < 3; i++) learn_pulse(i, i + 2);
      for (i = 0; i < 3; i++) rd_chk(14'(IDX_CNT0 + i), 32'(i + 2), RESP_OKAY);
      for (i = 0; i < 3; i++) rd_chk(14'(IDX_CNT0 + i), CNT_RST, RESP_OKAY);
      irq_chk(1'b0);
      rd_chk(IDX_EVSTAT, 32'h0000_0007, RESP_OKAY);
      rd_chk(IDX_EVSTAT, 32'h0000_0000, RESP_OKAY);
      pending <= 1'b1;
      irq_chk(1'b0);
      wr_chk(IDX_MASK, 32'hFFFF_FFFE, RESP_OKAY);
      irq_chk(1'b1);
      rd_chk(IDX_MASK, 32'h0000_0000, RESP_OKAY);
      pending <= 1'b0;
      irq_chk(1'b0);
      learn_pulse(1, 1);
      irq_chk(1'b1);
      rd_chk(IDX_EVSTAT, 32'h0000_0002, RESP_OKAY);
      irq_chk(1'b0);
      wr_chk(IDX_MASK, 32'h0000_0001, RESP_OKAY);
      // Lane 0 disabled, so the mask bit must survive a write of zero.
      wstrb <= 4'hE;
      wr_chk(IDX_MASK, 32'h0000_0000, RESP_OKAY);
      wstrb <= 4'hF;
      pending <= 1'b1;
      irq_chk(1'b0);
      pending <= 1'b0;
      // An unmapped index must answer with an error and zero data.
      rd_chk(14'h0100, 32'h0000_0000, RESP_SLVERR);
      wr_chk(14'h0100, 32'hFFFF_FFFF, RESP_SLVERR);
      wr_chk(IDX_CNT1, 32'hFFFF_FFFF, RESP_OKAY);
      rd_chk(IDX_CNT1, 32'h0000_0001, RESP_OKAY);
      wr_chk(IDX_MASK, 32'h0000_0000, RESP_OKAY);
      wr_chk(IDX_EVMASK, 32'h0000_0007, RESP_OKAY);
      learn_pulse(2, 1);
      irq_chk(1'b0);
      rd_chk(IDX_EVMASK, 32'h0000_0007, RESP_OKAY);
      rd_chk(IDX_EVSTAT, 32'h0000_0004, RESP_OKAY);
      finish_test();
   end
endmodule
